// ---- logic/rpi_host_pins.sv ----
// Host-facing pin logic: serial routing, status lines, amplifier enables, button, indicator
`timescale 1ns/1ps
module rpi_host_pins #(
   parameter int HOLD_CYCLES = rpi_pkg::CRF_HOLD_CYC,
   parameter int FLASH_UNIT = rpi_pkg::ms_to_cycles(rpi_pkg::FLASH_UNIT_MS),
   parameter int PB_DEBOUNCE = rpi_pkg::ms_to_cycles(rpi_pkg::PB_DEBOUNCE_MS),
   parameter int PB_WINDOW = rpi_pkg::ms_to_cycles(rpi_pkg::PB_WINDOW_MS),
   parameter int PB_JOIN = rpi_pkg::PB_JOIN_PRESSES,
   parameter int PB_RESTORE = rpi_pkg::PB_RESTORE_PRESSES
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic cmd_select_in,
   input wire logic power_down_n,
   input wire logic push_button_in,
   input wire logic [7:0] in_byte,
   input wire logic in_valid,
   output logic cts_n,
   output logic [7:0] route_byte,
   output logic cmd_valid,
   output logic pay_valid,
   input wire logic route_ready,
   input wire logic [7:0] reply_byte,
   input wire logic reply_valid,
   output logic reply_ack,
   input wire logic [7:0] air_byte,
   input wire logic air_valid,
   output logic air_ack,
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   input wire logic tx_stop_done,
   output logic command_response_flag,
   input wire logic [rpi_pkg::EXC_W-1:0] exc_event,
   input wire logic [rpi_pkg::EXC_W-1:0] exc_mask,
   input wire logic exc_clear,
   output logic exception_out,
   input wire logic radio_rx_active,
   input wire logic radio_tx_active,
   input wire logic radio_idle,
   input wire logic ack_enable,
   input wire logic ack_rx,
   input wire logic retry_exc,
   output logic rx_amp_enable,
   output logic tx_amp_enable,
   output logic buffer_empty_flag,
   input wire logic [rpi_pkg::STATE_W-1:0] op_state,
   output logic activity_indicator,
   output logic join_req,
   output logic restore_req,
   output logic asleep,
   output logic [rpi_pkg::ST_W-1:0] status_word
);
   import rpi_pkg::*;

   // Pin synchroniser: stage one is read only by stage two
   logic [2:0] pin_s1_r;
   logic [2:0] pin_s2_r;
   logic cmd_sel;
   logic awake;
   logic pb_lvl;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_r <= 3'h0;
         pin_s2_r <= 3'h0;
      end else begin
         pin_s1_r <= {push_button_in, power_down_n, cmd_select_in};
         pin_s2_r <= pin_s1_r;
      end
   end
   assign cmd_sel = pin_s2_r[0];
   assign awake = pin_s2_r[1];
   assign pb_lvl = pin_s2_r[2];

   // Input path: bytes tagged with their mode as they enter the buffer
   rpi_stream_if #(.W(9)) bin();
   rpi_stream_if #(.W(9)) bout();
   rpi_buf2 #(.W(9), .DEPTH(2)) u_buf (
      .clock(clock),
      .rst_n(rst_n),
      .wr(bin.snk),
      .rd(bout.src)
   );
   assign bin.data = {cmd_sel, in_byte};
   assign bin.valid = in_valid & awake;

   logic [7:0] rb_r, rb_nxt;
   logic cv_r, cv_nxt, pv_r, pv_nxt, cts_r, cts_nxt;
   logic stage_free;
   assign stage_free = ~(cv_r | pv_r) | route_ready;
   assign bout.ready = stage_free;
   always_comb begin
      rb_nxt = rb_r;
      cv_nxt = cv_r & ~route_ready;
      pv_nxt = pv_r & ~route_ready;
      if (bout.valid && stage_free) begin
         rb_nxt = bout.data[7:0];
         cv_nxt = ~bout.data[8];
         pv_nxt = bout.data[8];
      end
      // Busy once a byte is held, leaving the spare slot for one in flight
      cts_nxt = ~awake | bout.valid | ~bin.ready;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         rb_r <= 8'h00;
         cv_r <= 1'b0;
         pv_r <= 1'b0;
         cts_r <= RST_CTS_N;
      end else begin
         rb_r <= rb_nxt;
         cv_r <= cv_nxt;
         pv_r <= pv_nxt;
         cts_r <= cts_nxt;
      end
   end

   // Output path: one serial line shared by replies and air payload
   logic [7:0] tb_r, tb_nxt;
   logic tv_r, tv_nxt, busy_r, busy_nxt, crf_r, crf_nxt, rack_r, rack_nxt, aack_r, aack_nxt;
   logic [31:0] hold_r, hold_nxt;
   logic take_rep, take_air, idle;
   assign idle = ~tv_r & ~busy_r & awake;
   assign take_rep = idle & reply_valid & ~rack_r & ~crf_r;
   assign take_air = idle & air_valid & ~aack_r & crf_r & ~take_rep;
   always_comb begin
      tb_nxt = tb_r;
      tv_nxt = tv_r & ~tx_ready;
      busy_nxt = busy_r;
      crf_nxt = crf_r;
      hold_nxt = (hold_r != 32'h0) ? hold_r - 32'h1 : hold_r;
      rack_nxt = take_rep;
      aack_nxt = take_air;
      if (tv_r && tx_ready) begin
         busy_nxt = 1'b1;
      end
      if (tx_stop_done) begin
         busy_nxt = 1'b0;
         hold_nxt = 32'(HOLD_CYCLES);
      end
      if (take_rep || take_air) begin
         tb_nxt = take_rep ? reply_byte : air_byte;
         tv_nxt = 1'b1;
      end else if (idle && hold_r == 32'h0) begin
         // Flip only with the line quiet and the hold spent
         if (crf_r && reply_valid && !rack_r) begin
            crf_nxt = 1'b0;
         end else if (!crf_r && air_valid && !aack_r && !reply_valid) begin
            crf_nxt = 1'b1;
         end
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         tb_r <= 8'h00;
         tv_r <= 1'b0;
         busy_r <= 1'b0;
         crf_r <= RST_CRF;
         hold_r <= 32'h0;
         rack_r <= 1'b0;
         aack_r <= 1'b0;
      end else begin
         tb_r <= tb_nxt;
         tv_r <= tv_nxt;
         busy_r <= busy_nxt;
         crf_r <= crf_nxt;
         hold_r <= hold_nxt;
         rack_r <= rack_nxt;
         aack_r <= aack_nxt;
      end
   end

   // Status lines
   logic exc_r, exc_nxt, pend_r, pend_nxt, be_r, be_nxt, rxa_r, rxa_nxt, txa_r, txa_nxt;
   always_comb begin
      exc_nxt = exc_r;
      if (exc_clear) begin
         exc_nxt = 1'b0;
      end
      // A new event in the clear cycle still wins
      if ((exc_event & exc_mask) != '0) begin
         exc_nxt = 1'b1;
      end
      pend_nxt = pend_r;
      if (ack_rx || retry_exc || !ack_enable) begin
         pend_nxt = 1'b0;
      end
      if (pv_r && route_ready && ack_enable) begin
         pend_nxt = 1'b1;
      end
      be_nxt = awake & ~bout.valid & ~pv_r & ~cv_r & radio_idle & ~pend_nxt;
      rxa_nxt = awake & radio_rx_active;
      txa_nxt = awake & radio_tx_active;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         exc_r <= 1'b0;
         pend_r <= 1'b0;
         be_r <= 1'b0;
         rxa_r <= 1'b0;
         txa_r <= 1'b0;
      end else begin
         exc_r <= exc_nxt;
         pend_r <= pend_nxt;
         be_r <= be_nxt;
         rxa_r <= rxa_nxt;
         txa_r <= txa_nxt;
      end
   end

   // Push button: debounce, then count presses inside a window
   logic pb_st_r, pb_st_nxt, join_r, join_nxt, rest_r, rest_nxt;
   logic [31:0] deb_r, deb_nxt, win_r, win_nxt;
   logic [3:0] np_r, np_nxt;
   always_comb begin
      pb_st_nxt = pb_st_r;
      deb_nxt = 32'h0;
      win_nxt = (win_r != 32'h0) ? win_r - 32'h1 : win_r;
      np_nxt = np_r;
      join_nxt = 1'b0;
      rest_nxt = 1'b0;
      if (pb_lvl != pb_st_r) begin
         deb_nxt = deb_r + 32'h1;
         if (deb_r >= 32'(PB_DEBOUNCE)) begin
            pb_st_nxt = pb_lvl;
            deb_nxt = 32'h0;
            if (pb_lvl) begin
               np_nxt = (np_r == 4'hf) ? np_r : np_r + 4'h1;
               win_nxt = 32'(PB_WINDOW);
            end
         end
      end
      if (win_r == 32'h1) begin
         join_nxt = awake & (np_r == 4'(PB_JOIN));
         rest_nxt = awake & (np_r == 4'(PB_RESTORE));
         np_nxt = 4'h0;
      end
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pb_st_r <= 1'b0;
         deb_r <= 32'h0;
         win_r <= 32'h0;
         np_r <= 4'h0;
         join_r <= 1'b0;
         rest_r <= 1'b0;
      end else begin
         pb_st_r <= pb_st_nxt;
         deb_r <= deb_nxt;
         win_r <= win_nxt;
         np_r <= np_nxt;
         join_r <= join_nxt;
         rest_r <= rest_nxt;
      end
   end

   // Activity indicator: on for (state + 1) slots of each flash period
   logic [31:0] fc_r, fc_nxt;
   logic [3:0] slot_r, slot_nxt;
   logic led_r, led_nxt;
   logic [ST_W-1:0] stw_r, stw_nxt;
   always_comb begin
      fc_nxt = fc_r + 32'h1;
      slot_nxt = slot_r;
      if (fc_r >= 32'(FLASH_UNIT) - 32'h1) begin
         fc_nxt = 32'h0;
         slot_nxt = (slot_r >= 4'(FLASH_SLOTS - 1)) ? 4'h0 : slot_r + 4'h1;
      end
      led_nxt = awake & (slot_r <= 4'(op_state));
      stw_nxt = '0;
      stw_nxt[ST_CRF] = crf_r;
      stw_nxt[ST_EXC] = exc_r;
      stw_nxt[ST_CTS] = cts_r;
      stw_nxt[ST_BE] = be_r;
      stw_nxt[ST_RXA] = rxa_r;
      stw_nxt[ST_TXA] = txa_r;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         fc_r <= 32'h0;
         slot_r <= 4'h0;
         led_r <= 1'b0;
         stw_r <= '0;
      end else begin
         fc_r <= fc_nxt;
         slot_r <= slot_nxt;
         led_r <= led_nxt;
         stw_r <= stw_nxt;
      end
   end

   assign cts_n = cts_r;
   assign route_byte = rb_r;
   assign cmd_valid = cv_r;
   assign pay_valid = pv_r;
   assign reply_ack = rack_r;
   assign air_ack = aack_r;
   assign tx_byte = tb_r;
   assign tx_valid = tv_r;
   assign command_response_flag = crf_r;
   assign exception_out = exc_r;
   assign rx_amp_enable = rxa_r;
   assign tx_amp_enable = txa_r;
   assign buffer_empty_flag = be_r;
   assign activity_indicator = led_r;
   assign join_req = join_r;
   assign restore_req = rest_r;
   assign asleep = ~awake;
   assign status_word = stw_r;
endmodule // rpi_host_pins

// ---- logic/rpi_pkg.sv ----
// Shared constants for the host pin interface block
package rpi_pkg;
   localparam longint CLK_HZ = 100_000_000;
   localparam longint UART_BAUD = 115_200;
   localparam longint CRF_HOLD_BITS = 10;
   // Least hold time, so the count rounds up
   localparam int CRF_HOLD_CYC = int'((CRF_HOLD_BITS * CLK_HZ + UART_BAUD - 1) / UART_BAUD);
   localparam int FLASH_UNIT_MS = 100;
   localparam int FLASH_SLOTS = 8;
   localparam int PB_DEBOUNCE_MS = 20;
   localparam int PB_WINDOW_MS = 2000;
   localparam int PB_JOIN_PRESSES = 2;
   localparam int PB_RESTORE_PRESSES = 4;
   localparam int EXC_W = 8;
   localparam int STATE_W = 2;
   localparam logic RST_CRF = 1'b1;
   localparam logic RST_CTS_N = 1'b1;
   localparam int ST_CRF = 0;
   localparam int ST_EXC = 1;
   localparam int ST_CTS = 2;
   localparam int ST_BE = 3;
   localparam int ST_RXA = 4;
   localparam int ST_TXA = 5;
   localparam int ST_W = 6;

   function automatic int ms_to_cycles(input int ms);
      ms_to_cycles = int'((longint'(ms) * CLK_HZ) / 1000);
   endfunction
endpackage

// ---- logic/rpi_stream_if.sv ----
// Valid/ready byte stream between the block's own modules
`timescale 1ns/1ps
interface rpi_stream_if #(parameter int W = 9);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface

// ---- logic/rpi_buf2.sv ----
// Two-entry shift buffer; head entry always sits in slot 0
`timescale 1ns/1ps
module rpi_buf2 #(
   parameter int W = 9,
   parameter int DEPTH = 2
) (
   input wire logic clock,
   input wire logic rst_n,
   rpi_stream_if.snk wr,
   rpi_stream_if.src rd
);
   import rpi_pkg::*;
   logic [W-1:0] mem_r [DEPTH];
   logic [W-1:0] mem_nxt [DEPTH];
   logic [DEPTH-1:0] vld_r;
   logic [DEPTH-1:0] vld_nxt;
   logic pop;
   logic push;

   assign wr.ready = ~vld_r[DEPTH-1];
   assign rd.valid = vld_r[0];
   assign rd.data = mem_r[0];
   assign pop = rd.valid & rd.ready;
   assign push = wr.valid & wr.ready;

   always_comb begin
      mem_nxt = mem_r;
      vld_nxt = vld_r;
      if (pop) begin
         for (int i = 0; i < DEPTH - 1; i++) begin
            mem_nxt[i] = mem_r[i+1];
            vld_nxt[i] = vld_r[i+1];
         end
         vld_nxt[DEPTH-1] = 1'b0;
      end
      if (push) begin
         // Entries stay packed from slot 0, so an empty slot 0 means an empty buffer
         for (int i = DEPTH - 1; i > 0; i--) begin
            if (!vld_nxt[i] && vld_nxt[i-1]) begin
               mem_nxt[i] = wr.data;
               vld_nxt[i] = 1'b1;
            end
         end
         if (!vld_nxt[0]) begin
            mem_nxt[0] = wr.data;
            vld_nxt[0] = 1'b1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         vld_r <= '0;
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= '0;
         end
      end else begin
         vld_r <= vld_nxt;
         mem_r <= mem_nxt;
      end
   end
endmodule // rpi_buf2

// ---- test/rpi_host_chk.sv ----
// Port-level checker for the host pin block
`timescale 1ns/1ps
module rpi_host_chk #(
   parameter int HOLD_CYCLES = 20
) (
   input wire logic clock,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic cts_n,
   input wire logic cmd_valid,
   input wire logic pay_valid,
   input wire logic [7:0] reply_byte,
   input wire logic reply_ack,
   input wire logic air_ack,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_stop_done,
   input wire logic command_response_flag,
   input wire logic [rpi_pkg::EXC_W-1:0] exc_event,
   input wire logic [rpi_pkg::EXC_W-1:0] exc_mask,
   input wire logic exception_out,
   input wire logic radio_rx_active,
   input wire logic radio_tx_active,
   input wire logic rx_amp_enable,
   input wire logic tx_amp_enable,
   input wire logic buffer_empty_flag,
   input wire logic join_req,
   input wire logic restore_req,
   input wire logic asleep
);
   import rpi_pkg::*;
   // Cycles since the last stop bit ended; saturates so reset allows a switch
   int since_r;
   int since_nxt;
   always_comb begin
      since_nxt = since_r;
      if (tx_stop_done) since_nxt = 0;
      else if (since_r < HOLD_CYCLES) since_nxt = since_r + 1;
   end
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) since_r <= HOLD_CYCLES;
      else since_r <= since_nxt;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (!rst_n);
   AST_CRF_REPLY: assert property (reply_ack |-> !command_response_flag && tx_valid
      && tx_byte == $past(reply_byte)) else $error("reply sent without low flag or byte");
   AST_CRF_AIR: assert property (air_ack |-> command_response_flag && tx_valid)
      else $error("air byte sent with low response flag");
   AST_CRF_HOLD: assert property ($changed(command_response_flag) |->
      since_r >= HOLD_CYCLES) else $error("response flag changed too soon");
   AST_EXC_SET: assert property (|(exc_event & exc_mask) |=> exception_out)
      else $error("enabled exception not flagged");
   AST_EXC_QUIET: assert property (!exception_out && !(|(exc_event & exc_mask))
      |=> !exception_out) else $error("exception raised without enabled cause");
   AST_ROUTE_ONE: assert property (!(cmd_valid && pay_valid))
      else $error("byte routed both ways");
   AST_CTS_BUSY: assert property (in_valid && !cts_n && !asleep |-> ##[1:2] cts_n)
      else $error("clear to send stayed low after a byte");
   AST_RX_AMP: assert property (!asleep |=> rx_amp_enable == $past(radio_rx_active))
      else $error("receive amplifier enable wrong");
   AST_TX_AMP: assert property (!asleep |=> tx_amp_enable == $past(radio_tx_active))
      else $error("transmit amplifier enable wrong");
   AST_BE_SLEEP: assert property (asleep |=> !buffer_empty_flag)
      else $error("buffer empty shown while asleep");
   AST_BTN_PULSE: assert property (join_req || restore_req |=> !join_req && !restore_req)
      else $error("button request longer than one cycle");
   COV_REPLY: cover property (reply_ack);
   COV_AIR: cover property (air_ack);
   COV_JOIN: cover property (join_req);
endmodule // rpi_host_chk

// ---- test/rpi_uart_model.sv ----
// Serial transmitter model: takes bytes, can stall, and ends each frame
`timescale 1ns/1ps
module rpi_uart_model #(
   parameter int FRAME = 6
) (
   input wire logic clock,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready,
   output logic tx_stop_done
);
   logic [7:0] seen[$];
   int slow = 0;
   initial begin
      tx_ready = 1'b0;
      tx_stop_done = 1'b0;
      forever begin
         @(posedge clock);
         #1;
         if (tx_valid === 1'b1) begin
            seen.push_back(tx_byte);
            repeat (slow) @(posedge clock);
            #1 tx_ready = 1'b1;
            @(posedge clock);
            #1 tx_ready = 1'b0;
            // Frame time on the line before the stop bit ends
            repeat (FRAME) @(posedge clock);
            #1 tx_stop_done = 1'b1;
            @(posedge clock);
            #1 tx_stop_done = 1'b0;
         end
      end
   end
endmodule // rpi_uart_model

// ---- test/testbench.sv ----
// Directed bench for the host pin block
`timescale 1ns/1ps
module testbench;
   import rpi_pkg::*;
   localparam int HOLD = 20;
   localparam int UNIT = 4;
   logic clock = 1'b0, rst_n = 1'b0, cmd_select_in = 1'b0, power_down_n = 1'b1;
   logic push_button_in = 1'b0, in_valid = 1'b0, route_ready = 1'b0, reply_valid = 1'b0;
   logic air_valid = 1'b0, exc_clear = 1'b0, radio_rx_active = 1'b0, radio_tx_active = 1'b0;
   logic radio_idle = 1'b1, ack_enable = 1'b1, ack_rx = 1'b0, retry_exc = 1'b0;
   logic [7:0] in_byte = 8'h00, reply_byte = 8'h00, air_byte = 8'h00, route_byte, tx_byte;
   logic [EXC_W-1:0] exc_event = 8'h00, exc_mask = 8'h00;
   logic [STATE_W-1:0] op_state = 2'h0;
   logic [ST_W-1:0] status_word;
   logic cts_n, cmd_valid, pay_valid, reply_ack, air_ack, tx_valid, tx_ready, tx_stop_done;
   logic command_response_flag, exception_out, rx_amp_enable, tx_amp_enable, asleep;
   logic buffer_empty_flag, activity_indicator, join_req, restore_req, j, r;
   logic [7:0] got[$];
   int n_errors = 0;
   int total_checks = 0;
   always #5 clock = ~clock;
   rpi_host_pins #(.HOLD_CYCLES(HOLD), .FLASH_UNIT(UNIT), .PB_DEBOUNCE(3), .PB_WINDOW(50))
      u_rpi_host_pins (.*);
   rpi_uart_model u_rpi_uart_model (.clock(clock), .tx_byte(tx_byte), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_stop_done(tx_stop_done));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tally_and_finish;
      if (n_errors == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic pulse(ref logic s);
      s = 1'b1;
      tick(1);
      s = 1'b0;
   endtask
   task automatic await(ref logic s, input int lim);
      for (int i = 0; i < lim && s !== 1'b1; i++) tick(1);
      chk("await", s, 8'h01);
   endtask
   // Back-to-back bytes, one per cycle, as the receiver would hand them over
   task automatic send(input logic [7:0] b, input int n);
      in_valid = 1'b1;
      for (int i = 0; i < n; i++) begin
         in_byte = b + 8'(i);
         tick(1);
      end
      in_valid = 1'b0;
   endtask
   // Consumer stalls every other cycle so the buffer must hold its words
   task automatic drain;
      got.delete();
      for (int i = 0; i < 16; i++) begin
         route_ready = i[0];
         if ((cmd_valid | pay_valid) & route_ready) got.push_back(route_byte);
         tick(1);
      end
      route_ready = 1'b0;
   endtask
   task automatic fire(input logic [7:0] ev);
      exc_event = ev;
      tick(1);
      exc_event = 8'h00;
      tick(2);
   endtask
   task automatic presses(input int n);
      for (int i = 0; i < n; i++) begin
         push_button_in = 1'b1;
         tick(6);
         push_button_in = 1'b0;
         tick(6);
      end
      j = 1'b0;
      r = 1'b0;
      for (int i = 0; i < 80; i++) begin
         j |= join_req;
         r |= restore_req;
         tick(1);
      end
   endtask
   initial begin
      int n;
      tick(3);
      chk("crf_rst", command_response_flag, 8'h01);
      chk("cts_rst", cts_n, 8'h01);
      rst_n = 1'b1;
      tick(4);
      chk("cts_up", cts_n, 8'h00);
      chk("be_idle", buffer_empty_flag, 8'h01);
      for (int m = 0; m < 2; m++) begin
         cmd_select_in = m[0];
         tick(3);
         send(8'h30, 1);
         tick(1);
         chk("route", {cmd_valid, pay_valid, route_byte[5:0]}, {~m[0], m[0], 6'h30});
         chk("cts_busy", cts_n, 8'h01);
         drain;
         chk("one_byte", 8'(got.size()), 8'h01);
         chk("cts_free", cts_n, 8'h00);
      end
      chk("be_ack_wait", buffer_empty_flag, 8'h00);
      pulse(ack_rx);
      tick(3);
      chk("be_acked", buffer_empty_flag, 8'h01);
      send(8'h40, 5);
      drain;
      chk("refused", 8'(got.size() < 5 && got.size() > 1), 8'h01);
      foreach (got[i]) chk("order", got[i], 8'h40 + 8'(i));
      pulse(retry_exc);
      tick(3);
      chk("be_retry", buffer_empty_flag, 8'h01);
      radio_idle = 1'b0;
      tick(2);
      chk("be_radio", buffer_empty_flag, 8'h00);
      radio_idle = 1'b1;
      ack_enable = 1'b0;
      send(8'h50, 1);
      drain;
      chk("be_noack", buffer_empty_flag, 8'h01);
      ack_enable = 1'b1;
      u_rpi_uart_model.slow = 3;
      reply_byte = 8'ha5;
      reply_valid = 1'b1;
      await(reply_ack, 20);
      reply_valid = 1'b0;
      chk("crf_reply", command_response_flag, 8'h00);
      air_byte = 8'h5a;
      air_valid = 1'b1;
      await(air_ack, HOLD + 40);
      air_valid = 1'b0;
      chk("crf_air", command_response_flag, 8'h01);
      tick(20);
      chk("line_n", 8'(u_rpi_uart_model.seen.size()), 8'h02);
      chk("line_0", u_rpi_uart_model.seen[0], 8'ha5);
      chk("line_1", u_rpi_uart_model.seen[1], 8'h5a);
      exc_mask = 8'h0f;
      fire(8'h10);
      chk("exc_masked", exception_out, 8'h00);
      fire(8'h04);
      chk("exc_set", exception_out, 8'h01);
      chk("status", 8'(status_word), 8'h0b);
      pulse(exc_clear);
      tick(2);
      chk("exc_clr", exception_out, 8'h00);
      for (logic [2:0] m = 3'h1; m < 3'h4; m++) begin
         {radio_tx_active, radio_rx_active} = m[1:0];
         tick(3);
         chk("amps", {tx_amp_enable, rx_amp_enable}, m[1:0]);
         chk("amp_status", status_word[5:4], m[1:0]);
      end
      {radio_tx_active, radio_rx_active} = 2'h0;
      for (int m = 0; m < 4; m++) begin
         op_state = m[1:0];
         tick(40);
         for (int i = 0; i < 40 && activity_indicator !== 1'b0; i++) tick(1);
         for (int i = 0; i < 40 && activity_indicator !== 1'b1; i++) tick(1);
         n = 0;
         while (activity_indicator === 1'b1 && n < 60) begin
            n++;
            tick(1);
         end
         chk("flash", 8'(n), 8'((m + 1) * UNIT));
      end
      presses(2);
      chk("join", {j, r}, 8'h02);
      presses(4);
      chk("restore", {j, r}, 8'h01);
      presses(3);
      chk("no_seq", {j, r}, 8'h00);
      power_down_n = 1'b0;
      tick(3);
      chk("asleep", {asleep, cts_n, buffer_empty_flag}, 8'h06);
      send(8'h77, 1);
      tick(4);
      chk("drop", pay_valid, 8'h00);
      power_down_n = 1'b1;
      tick(4);
      chk("wake", {asleep, cts_n}, 8'h00);
      rst_n = 1'b0;
      tick(1);
      chk("rst_mid", {command_response_flag, cts_n}, 8'h03);
      rst_n = 1'b1;
      tick(4);
      chk("cts_again", cts_n, 8'h00);
      tally_and_finish();
   end
   // Whole run is about a thousand cycles; this only trips on a hang
   initial begin
      #100us;
      n_errors++;
      tally_and_finish();
   end
endmodule // testbench
bind rpi_host_pins rpi_host_chk #(.HOLD_CYCLES(HOLD_CYCLES)) u_rpi_host_chk (.*);
